// ---- core/afs_flags_core.sv ----
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module afs_flags_core #(
   parameter int PTR_W = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             exec_valid,
   input  afs_pkg::afs_op_t      exec_op,
   input  wire logic             exec_src_file,
   input  wire logic [2:0]       exec_bit,
   input  wire logic [7:0]       exec_wreg,
   input  wire logic [7:0]       exec_file,
   input  wire logic [7:0]       exec_literal,
   input  wire logic             exec_dest_file,
   input  wire logic [7:0]       exec_dest_addr,
   input  wire logic             ind0_access,
   input  wire logic             ind1_access,
   output logic      [7:0]       exec_result,
   output logic                  exec_result_valid,
   output logic      [7:0]       alu_flags_and_pointer_mode,
   output logic      [PTR_W-1:0] first_indirect_pointer,
   output logic      [PTR_W-1:0] second_indirect_pointer
);

   // ****************************************************************
   // Operand selection and the arithmetic unit.
   // ****************************************************************
   afs_alu_if  alu_bus ();
   logic       two_operand;
   logic [7:0] opb_sel;
   logic [3:0] affects;
   logic [3:0] next_status;
   logic       dest_flags;
   logic       dest_ptr0;
   logic       dest_ptr1;

   always_comb begin
      case (exec_op)
         afs_pkg::AFS_ADD_FILE, afs_pkg::AFS_ADD_CARRY,
         afs_pkg::AFS_SUBTRACT, afs_pkg::AFS_AND,
         afs_pkg::AFS_IOR, afs_pkg::AFS_XOR: two_operand = 1'b1;
         default: two_operand = 1'b0;
      endcase
   end

   // Single operand ops read the file or the working register; two
   // operand ops pair the working register with file or literal.
   assign opb_sel = exec_src_file ? exec_file :
                    (two_operand ? exec_literal : exec_wreg);

   assign alu_bus.op       = exec_op;
   assign alu_bus.opa      = exec_wreg;
   assign alu_bus.opb      = opb_sel;
   assign alu_bus.carry_in = alu_flags_and_pointer_mode[afs_pkg::C_BIT];
   assign alu_bus.bit_sel  = exec_bit;

   afs_alu u_alu (
      .port_alu (alu_bus.alu)
   );

   assign affects    = afs_pkg::afs_affects(exec_op);
   assign dest_flags = exec_dest_file &&
                       exec_dest_addr == afs_pkg::FLAGS_FILE_ADDR;
   assign dest_ptr0  = exec_dest_file &&
                       exec_dest_addr == afs_pkg::PTR0_FILE_ADDR;
   assign dest_ptr1  = exec_dest_file &&
                       exec_dest_addr == afs_pkg::PTR1_FILE_ADDR;

   // ****************************************************************
   // Bus slave strobes.
   // ****************************************************************
   logic wb_req;
   logic wr_fire;
   logic wr_flags;
   logic wr_ptr0;
   logic wr_ptr1;

   assign wb_req   = wb_cyc_i && wb_stb_i;
   assign wr_fire  = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign wr_flags = wr_fire && wb_adr_i == afs_pkg::WB_FLAGS_OFS;
   assign wr_ptr0  = wr_fire && wb_adr_i == afs_pkg::WB_PTR0_OFS;
   assign wr_ptr1  = wr_fire && wb_adr_i == afs_pkg::WB_PTR1_OFS;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req && !wb_ack_o;
      end
   end

   // Unmapped offsets still answer, reading zero, so a stray access
   // cannot hang the bus.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_ack_o && !wb_we_i) begin
         case (wb_adr_i)
            afs_pkg::WB_FLAGS_OFS:
               wb_dat_o <= {24'h00_0000, alu_flags_and_pointer_mode};
            afs_pkg::WB_PTR0_OFS:
               wb_dat_o <= 32'(first_indirect_pointer);
            afs_pkg::WB_PTR1_OFS:
               wb_dat_o <= 32'(second_indirect_pointer);
            afs_pkg::WB_RESULT_OFS:
               wb_dat_o <= {24'h00_0000, exec_result};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // Flags and pointer mode register.
   // ****************************************************************
   // The low nibble keeps a bit unless the operation drives it. When
   // the register is the destination and the op touches null, nibble
   // or msb status, the data write to the low nibble is dropped.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (affects[i]) begin
            next_status[i] = alu_bus.flags[i];
         end else if (dest_flags && affects[2:0] == 3'h0) begin
            next_status[i] = alu_bus.result[i];
         end else begin
            next_status[i] = alu_flags_and_pointer_mode[i];
         end
      end
   end

   // An instruction in the same cycle as a bus write wins.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         alu_flags_and_pointer_mode <= afs_pkg::FLAGS_RESET;
      end else if (exec_valid && dest_flags) begin
         alu_flags_and_pointer_mode <= {alu_bus.result[7:4],
                                        next_status};
      end else if (exec_valid) begin
         alu_flags_and_pointer_mode[3:0] <= next_status;
      end else if (wr_flags) begin
         alu_flags_and_pointer_mode <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         exec_result       <= 8'h00;
         exec_result_valid <= 1'b0;
      end else begin
         exec_result_valid <= exec_valid;
         if (exec_valid) begin
            exec_result <= alu_bus.result;
         end
      end
   end

   // ****************************************************************
   // Indirect pointers.
   // ****************************************************************
   logic             ld_ptr0;
   logic             ld_ptr1;
   logic [PTR_W-1:0] ld_val0;
   logic [PTR_W-1:0] ld_val1;

   assign ld_ptr0 = (exec_valid && dest_ptr0) || wr_ptr0;
   assign ld_ptr1 = (exec_valid && dest_ptr1) || wr_ptr1;
   assign ld_val0 = (exec_valid && dest_ptr0) ?
                    PTR_W'(alu_bus.result) : wb_dat_i[PTR_W-1:0];
   assign ld_val1 = (exec_valid && dest_ptr1) ?
                    PTR_W'(alu_bus.result) : wb_dat_i[PTR_W-1:0];

   afs_pointer #(
      .W (PTR_W)
   ) u_ptr0 (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .mode       (alu_flags_and_pointer_mode[afs_pkg::MODE1_LO +: 2]),
      .access     (ind0_access),
      .load       (ld_ptr0),
      .load_value (ld_val0),
      .value      (first_indirect_pointer)
   );

   afs_pointer #(
      .W (PTR_W)
   ) u_ptr1 (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .mode       (alu_flags_and_pointer_mode[afs_pkg::MODE2_LO +: 2]),
      .access     (ind1_access),
      .load       (ld_ptr1),
      .load_value (ld_val1),
      .value      (second_indirect_pointer)
   );

   // ****************************************************************
   // Checks.
   // ****************************************************************
   // Reference sums are formed independently of the unit above.
   logic [8:0]        chk_sum;
   logic [4:0]        chk_half;
   logic signed [8:0] chk_ssum;
   logic              chk_add;

   assign chk_sum  = {1'b0, exec_wreg} + {1'b0, opb_sel};
   assign chk_half = {1'b0, exec_wreg[3:0]} + {1'b0, opb_sel[3:0]};
   assign chk_ssum = $signed({exec_wreg[7], exec_wreg}) +
                     $signed({opb_sel[7], opb_sel});
   assign chk_add  = exec_valid && exec_op == afs_pkg::AFS_ADD_FILE;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_move_to_flags;
      exec_valid && dest_flags && exec_op == afs_pkg::AFS_MOVE_WREG
      |=> alu_flags_and_pointer_mode == $past(exec_wreg);
   endproperty
   a_move_to_flags: assert property (p_move_to_flags)
      else $error("Move into flags register did not store data.");

   property p_suppress_write;
      chk_add && dest_flags
      |=> alu_flags_and_pointer_mode[2:0] ==
          {($past(chk_sum[7:0]) == 8'h00), $past(chk_half[4]),
           $past(chk_sum[8])};
   endproperty
   a_suppress_write: assert property (p_suppress_write)
      else $error("Data overwrote msb-out bit on flag-affecting write.");

   property p_clear_pattern;
      exec_valid && dest_flags && exec_op == afs_pkg::AFS_CLEAR_FILE
      |=> alu_flags_and_pointer_mode[7:4] == 4'h0 &&
          alu_flags_and_pointer_mode[afs_pkg::Z_BIT] &&
          alu_flags_and_pointer_mode[3] ==
             $past(alu_flags_and_pointer_mode[3]) &&
          alu_flags_and_pointer_mode[1:0] ==
             $past(alu_flags_and_pointer_mode[1:0]);
   endproperty
   a_clear_pattern: assert property (p_clear_pattern)
      else $error("Clear of flags register gave wrong pattern.");

   property p_ptr1_decrement;
      ind1_access && !ld_ptr1 &&
      alu_flags_and_pointer_mode[7:6] == afs_pkg::MODE_DEC
      |=> second_indirect_pointer ==
          $past(second_indirect_pointer) - PTR_W'(1);
   endproperty
   a_ptr1_decrement: assert property (p_ptr1_decrement)
      else $error("Second pointer did not post-decrement.");

   property p_ptr1_hold;
      ind1_access && !ld_ptr1 && alu_flags_and_pointer_mode[7]
      |=> $stable(second_indirect_pointer);
   endproperty
   a_ptr1_hold: assert property (p_ptr1_hold)
      else $error("Second pointer moved in hold mode.");

   property p_ptr0_increment;
      ind0_access && !ld_ptr0 &&
      alu_flags_and_pointer_mode[5:4] == afs_pkg::MODE_INC
      |=> first_indirect_pointer ==
          $past(first_indirect_pointer) + PTR_W'(1);
   endproperty
   a_ptr0_increment: assert property (p_ptr0_increment)
      else $error("First pointer did not post-increment.");

   property p_ptr0_hold;
      ind0_access && !ld_ptr0 && alu_flags_and_pointer_mode[5]
      |=> $stable(first_indirect_pointer);
   endproperty
   a_ptr0_hold: assert property (p_ptr0_hold)
      else $error("First pointer moved in hold mode.");

   property p_signed_range;
      chk_add && !dest_flags
      |=> alu_flags_and_pointer_mode[afs_pkg::RANGE_BIT] ==
          ($past(chk_ssum) > 9'sd127 || $past(chk_ssum) < -9'sd128);
   endproperty
   a_signed_range: assert property (p_signed_range)
      else $error("Signed range flag wrong after addition.");

   property p_add_nibble;
      chk_add |-> alu_bus.flags[afs_pkg::NIBBLE_BIT] == chk_half[4];
   endproperty
   a_add_nibble: assert property (p_add_nibble)
      else $error("Nibble-out bit wrong after addition.");

   property p_add_msb;
      chk_add && !dest_flags
      |=> alu_flags_and_pointer_mode[afs_pkg::C_BIT] == $past(chk_sum[8]);
   endproperty
   a_add_msb: assert property (p_add_msb)
      else $error("Msb-out bit wrong after addition.");

   property p_sub_borrow;
      exec_valid && exec_op == afs_pkg::AFS_SUBTRACT
      |-> alu_bus.flags[afs_pkg::C_BIT] == (opb_sel >= exec_wreg) &&
          alu_bus.flags[afs_pkg::NIBBLE_BIT] ==
             (opb_sel[3:0] >= exec_wreg[3:0]);
   endproperty
   a_sub_borrow: assert property (p_sub_borrow)
      else $error("Borrow polarity wrong after subtraction.");

   property p_rotate_left;
      exec_valid && exec_op == afs_pkg::AFS_ROT_LEFT && !dest_flags
      |=> alu_flags_and_pointer_mode[afs_pkg::C_BIT] == $past(opb_sel[7]);
   endproperty
   a_rotate_left: assert property (p_rotate_left)
      else $error("Left rotate did not load msb-out bit.");

   property p_rotate_right;
      exec_valid && exec_op == afs_pkg::AFS_ROT_RIGHT
      |-> alu_bus.flags[afs_pkg::C_BIT] == opb_sel[0];
   endproperty
   a_rotate_right: assert property (p_rotate_right)
      else $error("Right rotate did not load msb-out bit.");

   property p_literal_operand;
      exec_valid && exec_op == afs_pkg::AFS_XOR && !exec_src_file
      |=> exec_result == $past(exec_wreg ^ exec_literal);
   endproperty
   a_literal_operand: assert property (p_literal_operand)
      else $error("Literal operand not used by two-operand op.");

   property p_read_flags;
      wb_ack_o && !wb_we_i && wb_adr_i == afs_pkg::WB_FLAGS_OFS
      |-> wb_dat_o == {24'h00_0000, $past(alu_flags_and_pointer_mode)};
   endproperty
   a_read_flags: assert property (p_read_flags)
      else $error("Bus read of flags register returned wrong value.");

   property p_null_result;
      exec_valid && exec_op == afs_pkg::AFS_AND && !dest_flags
      |=> alu_flags_and_pointer_mode[afs_pkg::Z_BIT] ==
          (exec_result == 8'h00);
   endproperty
   a_null_result: assert property (p_null_result)
      else $error("Null-result bit disagrees with result.");

   property p_ack_single;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("Bus acknowledge held longer than one cycle.");

   c_clear_flags: cover property (exec_valid && dest_flags &&
                                  exec_op == afs_pkg::AFS_CLEAR_FILE);
   c_add_overflow: cover property (chk_add && alu_bus.flags[3]);
   c_ptr_decrement: cover property (ind1_access &&
                                    alu_flags_and_pointer_mode[7:6] ==
                                    afs_pkg::MODE_DEC);
   c_bus_write: cover property (wr_flags);

endmodule

// ---- core/afs_pkg.sv ----
package afs_pkg;

   // ****************************************************************
   // Operations issued by the instruction decoder.
   // ****************************************************************
   typedef enum logic [3:0] {
      AFS_ADD_FILE   = 4'h0,
      AFS_ADD_CARRY  = 4'h1,
      AFS_SUBTRACT   = 4'h2,
      AFS_AND        = 4'h3,
      AFS_IOR        = 4'h4,
      AFS_XOR        = 4'h5,
      AFS_COMPLEMENT = 4'h6,
      AFS_CLEAR_FILE = 4'h7,
      AFS_ROT_LEFT   = 4'h8,
      AFS_ROT_RIGHT  = 4'h9,
      AFS_NIB_SWAP   = 4'hA,
      AFS_MOVE_WREG  = 4'hB,
      AFS_BIT_CLEAR  = 4'hC,
      AFS_BIT_SET    = 4'hD,
      AFS_INCREMENT  = 4'hE,
      AFS_DECREMENT  = 4'hF
   } afs_op_t;

   // ****************************************************************
   // File addresses, bus offsets, fields and reset values.
   // ****************************************************************
   localparam logic [7:0] FLAGS_FILE_ADDR = 8'h04;
   localparam logic [7:0] PTR0_FILE_ADDR  = 8'h01;
   localparam logic [7:0] PTR1_FILE_ADDR  = 8'h09;
   localparam logic [7:0] WB_FLAGS_OFS    = 8'h04;
   localparam logic [7:0] WB_PTR0_OFS     = 8'h08;
   localparam logic [7:0] WB_PTR1_OFS     = 8'h0C;
   localparam logic [7:0] WB_RESULT_OFS   = 8'h10;
   localparam int         MODE2_LO        = 6;
   localparam int         MODE1_LO        = 4;
   localparam int         RANGE_BIT       = 3;
   localparam int         Z_BIT           = 2;
   localparam int         NIBBLE_BIT      = 1;
   localparam int         C_BIT           = 0;
   localparam logic [1:0] MODE_DEC        = 2'h0;
   localparam logic [1:0] MODE_INC        = 2'h1;
   localparam logic [7:0] FLAGS_RESET     = 8'h00;
   localparam logic [7:0] PTR_RESET       = 8'h00;

   // Status bits an operation updates: range, null, nibble, msb.
   function automatic logic [3:0] afs_affects(input afs_op_t op);
      case (op)
         AFS_ADD_FILE, AFS_ADD_CARRY, AFS_SUBTRACT,
         AFS_INCREMENT, AFS_DECREMENT: afs_affects = 4'hF;
         AFS_AND, AFS_IOR, AFS_XOR,
         AFS_COMPLEMENT, AFS_CLEAR_FILE: afs_affects = 4'h4;
         AFS_ROT_LEFT, AFS_ROT_RIGHT: afs_affects = 4'h1;
         default: afs_affects = 4'h0;
      endcase
   endfunction

endpackage

// ---- core/afs_alu_if.sv ----
`timescale 1ns/1ps
interface afs_alu_if;
   afs_pkg::afs_op_t op;
   logic [7:0]       opa;
   logic [7:0]       opb;
   logic             carry_in;
   logic [2:0]       bit_sel;
   logic [7:0]       result;
   logic [3:0]       flags;

   modport core (output op, opa, opb, carry_in, bit_sel,
                 input  result, flags);
   modport alu  (input  op, opa, opb, carry_in, bit_sel,
                 output result, flags);
endinterface

// ---- core/afs_alu.sv ----
`timescale 1ns/1ps
module afs_alu (
   afs_alu_if.alu port_alu
);
   logic [7:0] x;
   logic [7:0] y;
   logic       ci;
   logic [8:0] sum;
   logic [4:0] half;
   logic [7:0] res;
   logic       cout;

   always_comb begin
      x  = port_alu.opa;
      y  = port_alu.opb;
      ci = 1'b0;
      case (port_alu.op)
         afs_pkg::AFS_ADD_CARRY: ci = port_alu.carry_in;
         afs_pkg::AFS_SUBTRACT: begin
            x  = port_alu.opb;
            y  = ~port_alu.opa;
            ci = 1'b1;
         end
         afs_pkg::AFS_INCREMENT: begin
            x  = port_alu.opb;
            y  = 8'h00;
            ci = 1'b1;
         end
         afs_pkg::AFS_DECREMENT: begin
            x  = port_alu.opb;
            y  = 8'hFF;
         end
         default: ci = 1'b0;
      endcase
      sum  = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      half = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      cout = sum[8];
      res  = sum[7:0];
      case (port_alu.op)
         afs_pkg::AFS_AND:        res = port_alu.opa & port_alu.opb;
         afs_pkg::AFS_IOR:        res = port_alu.opa | port_alu.opb;
         afs_pkg::AFS_XOR:        res = port_alu.opa ^ port_alu.opb;
         afs_pkg::AFS_COMPLEMENT: res = ~port_alu.opb;
         afs_pkg::AFS_CLEAR_FILE: res = 8'h00;
         afs_pkg::AFS_ROT_LEFT: begin
            res  = {port_alu.opb[6:0], port_alu.carry_in};
            cout = port_alu.opb[7];
         end
         afs_pkg::AFS_ROT_RIGHT: begin
            res  = {port_alu.carry_in, port_alu.opb[7:1]};
            cout = port_alu.opb[0];
         end
         afs_pkg::AFS_NIB_SWAP:   res = {port_alu.opb[3:0], port_alu.opb[7:4]};
         afs_pkg::AFS_MOVE_WREG:  res = port_alu.opa;
         afs_pkg::AFS_BIT_CLEAR:
            res = port_alu.opb & ~(8'h01 << port_alu.bit_sel);
         afs_pkg::AFS_BIT_SET:
            res = port_alu.opb | (8'h01 << port_alu.bit_sel);
         default: res = sum[7:0];
      endcase
      port_alu.result = res;
      port_alu.flags  = {(x[7] == y[7]) && (sum[7] != x[7]),
                         res == 8'h00, half[4], cout};
   end
endmodule

// ---- core/afs_pointer.sv ----
`timescale 1ns/1ps
module afs_pointer #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [1:0]   mode,
   input  wire logic         access,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   output logic      [W-1:0] value
);
   // A load in the same cycle as an access wins over the adjustment.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         value <= W'(afs_pkg::PTR_RESET);
      end else if (load) begin
         value <= load_value;
      end else if (access && mode == afs_pkg::MODE_DEC) begin
         value <= value - W'(1);
      end else if (access && mode == afs_pkg::MODE_INC) begin
         value <= value + W'(1);
      end
   end
endmodule

// ---- verification/afs_dec_model.sv ----
`timescale 1ns/1ps
// ***
// Decoder stand-in.
// ***
module afs_dec_model (
   input  wire logic        clk_sys,
   output logic             exec_valid,
   output afs_pkg::afs_op_t exec_op,
   output logic             exec_src_file,
   output logic [7:0]       exec_wreg,
   output logic [7:0]       exec_file,
   output logic [7:0]       exec_literal,
   output logic             exec_dest_file,
   output logic             ind0_access,
   output logic             ind1_access
);
   initial begin
      exec_valid = 1'b0;
      exec_op = afs_pkg::AFS_MOVE_WREG;
      exec_src_file = 1'b0;
      exec_wreg = 8'h00;
      exec_file = 8'h00;
      exec_literal = 8'h00;
      exec_dest_file = 1'b0;
      ind0_access = 1'b0;
      ind1_access = 1'b0;
   end
   // Operands are inverted once taken, so late sampling shows up.
   task automatic issue(input afs_pkg::afs_op_t op,
      input logic [7:0] w, f, l, input logic [1:0] m);
      @(posedge clk_sys);
      exec_valid <= 1'b1;
      exec_op <= op;
      exec_src_file <= m[0];
      exec_wreg <= w;
      exec_file <= f;
      exec_literal <= l;
      exec_dest_file <= m[1];
      @(posedge clk_sys);
      exec_valid <= 1'b0;
      exec_wreg <= ~w;
      exec_file <= ~f;
      exec_literal <= ~l;
      #1;
   endtask
   task automatic step(input logic a0, input logic a1);
      @(posedge clk_sys);
      ind0_access <= a0;
      ind1_access <= a1;
      @(posedge clk_sys);
      ind0_access <= 1'b0;
      ind1_access <= 1'b0;
   endtask
endmodule

// ---- verification/alu_status_flags_tb.sv ----
`timescale 1ns/1ps
// ***
// Bench for the status flags block.
// ***
module alu_status_flags_tb;
   localparam afs_pkg::afs_op_t op_add = afs_pkg::AFS_ADD_FILE;
   localparam afs_pkg::afs_op_t op_sub = afs_pkg::AFS_SUBTRACT;
   localparam afs_pkg::afs_op_t op_rl = afs_pkg::AFS_ROT_LEFT;
   localparam afs_pkg::afs_op_t op_rr = afs_pkg::AFS_ROT_RIGHT;
   localparam afs_pkg::afs_op_t op_clr = afs_pkg::AFS_CLEAR_FILE;
   localparam afs_pkg::afs_op_t op_mov = afs_pkg::AFS_MOVE_WREG;
   localparam afs_pkg::afs_op_t op_xor = afs_pkg::AFS_XOR;
   localparam afs_pkg::afs_op_t op_and = afs_pkg::AFS_AND;
   localparam afs_pkg::afs_op_t op_adc = afs_pkg::AFS_ADD_CARRY;
   localparam afs_pkg::afs_op_t op_inc = afs_pkg::AFS_INCREMENT;
   localparam afs_pkg::afs_op_t op_dec = afs_pkg::AFS_DECREMENT;
   localparam afs_pkg::afs_op_t op_com = afs_pkg::AFS_COMPLEMENT;
   localparam afs_pkg::afs_op_t op_swp = afs_pkg::AFS_NIB_SWAP;
   localparam afs_pkg::afs_op_t op_bst = afs_pkg::AFS_BIT_SET;
   localparam afs_pkg::afs_op_t op_bcl = afs_pkg::AFS_BIT_CLEAR;
   logic             clk_sys = 1'b0;
   logic             rst = 1'b1;
   logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0]       adr = 8'h00;
   logic [3:0]       sel = 4'h0;
   logic [31:0]      wdat = 32'h00000000, rdat;
   logic             valid, src_f, dest_f, acc0, acc1, res_v;
   afs_pkg::afs_op_t op;
   logic [7:0]       wreg, file, lit, res, flags, q, ptr0, ptr1;
   int               bad_count = 0, checked = 0, cycles = 0;
   logic [7:0]       m_mode [3] = '{8'h10, 8'h60, 8'h80};
   logic [7:0]       m_p0 [3] = '{8'h01, 8'h01, 8'h00};
   logic [7:0]       m_p1 [3] = '{8'hFF, 8'h00, 8'h00};

   always #5 clk_sys = ~clk_sys;

   afs_flags_core #(.PTR_W(8)) afs_flags_core_inst (
      .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .exec_valid(valid),
      .exec_op(op), .exec_src_file(src_f), .exec_bit(3'h0),
      .exec_wreg(wreg), .exec_file(file), .exec_literal(lit),
      .exec_dest_file(dest_f), .exec_dest_addr(afs_pkg::FLAGS_FILE_ADDR),
      .ind0_access(acc0), .ind1_access(acc1), .exec_result(res),
      .exec_result_valid(res_v), .alu_flags_and_pointer_mode(flags),
      .first_indirect_pointer(ptr0), .second_indirect_pointer(ptr1));
   afs_dec_model afs_dec_model_inst (
      .clk_sys(clk_sys), .exec_valid(valid), .exec_op(op),
      .exec_src_file(src_f), .exec_wreg(wreg), .exec_file(file),
      .exec_literal(lit), .exec_dest_file(dest_f),
      .ind0_access(acc0), .ind1_access(acc1));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   // Released write data is inverted so a late sample cannot match.
   task automatic wb(input logic w, input logic [7:0] a, d);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h000000, d};
      do @(posedge clk_sys); while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      wdat <= ~{24'h000000, d};
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   task automatic ex(input afs_pkg::afs_op_t o, input logic [7:0] w, f, l,
      input logic [1:0] m, input logic [7:0] er, ef);
      afs_dec_model_inst.issue(o, w, f, l, m);
      chk(res, er);
      chk({7'h00, res_v}, 8'h01);
      chk(flags, ef);
      rd(afs_pkg::WB_FLAGS_OFS, ef);
   endtask
   task automatic done(input string t);
      $display("test %s done", t);
   endtask
   task automatic results;
      $display("checked %0d, bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(afs_pkg::WB_FLAGS_OFS, 8'h00);
      rd(afs_pkg::WB_PTR0_OFS, 8'h00);
      wb(1'b1, 8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      rd(afs_pkg::WB_FLAGS_OFS, 8'h00);
      done("reset");
      ex(op_add, 8'h7F, 8'h01, 8'h00, 2'h1, 8'h80, 8'h0A);
      ex(op_add, 8'hFF, 8'h01, 8'h00, 2'h1, 8'h00, 8'h07);
      ex(op_add, 8'h10, 8'h99, 8'h20, 2'h0, 8'h30, 8'h00);
      done("add");
      ex(op_sub, 8'h03, 8'h99, 8'h05, 2'h0, 8'h02, 8'h03);
      ex(op_sub, 8'h05, 8'h99, 8'h03, 2'h0, 8'hFE, 8'h00);
      ex(op_sub, 8'h01, 8'h99, 8'h80, 2'h0, 8'h7F, 8'h09);
      done("subtract");
      ex(op_rl, 8'h00, 8'h99, 8'h00, 2'h0, 8'h01, 8'h08);
      ex(op_rr, 8'h01, 8'h99, 8'h00, 2'h0, 8'h00, 8'h09);
      done("rotate");
      ex(op_xor, 8'hF0, 8'h99, 8'h0F, 2'h0, 8'hFF, 8'h09);
      ex(op_and, 8'hF0, 8'h0F, 8'h00, 2'h1, 8'h00, 8'h0D);
      ex(op_adc, 8'h01, 8'h01, 8'h00, 2'h1, 8'h03, 8'h00);
      ex(op_inc, 8'hFF, 8'h99, 8'h00, 2'h0, 8'h00, 8'h07);
      ex(op_dec, 8'h00, 8'h99, 8'h00, 2'h0, 8'hFF, 8'h00);
      ex(op_com, 8'hFF, 8'h99, 8'h00, 2'h0, 8'h00, 8'h04);
      done("logic");
      wb(1'b1, afs_pkg::WB_FLAGS_OFS, 8'h00);
      ex(op_add, 8'h01, 8'hF0, 8'h00, 2'h3, 8'hF1, 8'hF0);
      wb(1'b1, afs_pkg::WB_FLAGS_OFS, 8'hFB);
      ex(op_clr, 8'h00, 8'h00, 8'h00, 2'h3, 8'h00, 8'h0F);
      ex(op_mov, 8'h5A, 8'h00, 8'h00, 2'h2, 8'h5A, 8'h5A);
      ex(op_swp, 8'hC3, 8'h00, 8'h00, 2'h2, 8'h3C, 8'h3C);
      ex(op_bst, 8'h3C, 8'h00, 8'h00, 2'h2, 8'h3D, 8'h3D);
      ex(op_bcl, 8'h3D, 8'h00, 8'h00, 2'h2, 8'h3C, 8'h3C);
      done("destination");
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, afs_pkg::WB_FLAGS_OFS, m_mode[i]);
         afs_dec_model_inst.step(1'b1, 1'b1);
         rd(afs_pkg::WB_PTR0_OFS, m_p0[i]);
         rd(afs_pkg::WB_PTR1_OFS, m_p1[i]);
         chk(ptr0, m_p0[i]);
         chk(ptr1, m_p1[i]);
      end
      rd(afs_pkg::WB_RESULT_OFS, 8'h3C);
      done("pointers");
      results();
   end
endmodule
